// ===== hw/etw_pkg.sv
/*
 * Shared constants for the three-wire data store port: the port control
 * register location and bit layout, serial instruction codes, the
 * controller's own register map and the store's sequencing states.
 * Assumes both ends are compiled after this package.
 */
package etw_pkg;

    // ==========================================================
    // Port control register location and layout
    // ==========================================================
    localparam logic PORT_BANK = 1'b1;
    localparam logic [6:0] PORT_OFFSET = 7'h40;
    localparam int BIT_SELECT = 4;
    localparam int BIT_SERIAL_CLOCK = 5;
    localparam int BIT_SERIAL_IN = 6;
    localparam int BIT_SERIAL_OUT = 7;
    localparam logic [3:0] PORT_LOW_BITS = 4'h0;

    // ==========================================================
    // Store geometry and serial instruction encoding
    // ==========================================================
    localparam int STORE_WORDS = 128;
    localparam logic [1:0] CODE_EXT = 2'h0;
    localparam logic [1:0] CODE_WRITE = 2'h1;
    localparam logic [1:0] CODE_READ = 2'h2;
    localparam logic [1:0] CODE_ERASE = 2'h3;
    localparam logic [1:0] EXT_DISABLE = 2'h0;
    localparam logic [1:0] EXT_WRITE_ALL = 2'h1;
    localparam logic [1:0] EXT_ERASE_ALL = 2'h2;
    localparam logic [1:0] EXT_ENABLE = 2'h3;
    localparam logic [2:0] CODE_LAST_BIT = 3'h1;
    localparam logic [2:0] ADDR_LAST_BIT = 3'h6;
    localparam logic [2:0] DATA_LAST_BIT = 3'h7;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    // ==========================================================
    // Internal write cycle timing
    // ==========================================================
    localparam int CLK_PERIOD_NS = 50;
    localparam int WRITE_TIME_NS = 2000;
    localparam int WR_CYCLES = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==========================================================
    // Controller register map (byte offsets on AHB-Lite)
    // ==========================================================
    localparam logic [7:0] REG_BANK = 8'h00;
    localparam logic [7:0] REG_POINTER = 8'h04;
    localparam logic [7:0] REG_WINDOW = 8'h08;
    localparam logic [7:0] REG_DIRECT_ADDR = 8'h0C;
    localparam logic [7:0] REG_DIRECT_DATA = 8'h10;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic [1:0] RD_WAIT_FIRST = 2'h1;
    localparam logic [1:0] RD_WAIT_SECOND = 2'h2;

    typedef enum {
        ST_IDLE,
        ST_CODE,
        ST_ADDR,
        ST_DATA,
        ST_READ,
        ST_HOLD,
        ST_BUSY
    } etw_state_t;

endpackage

// ===== hw/etw_if.sv
/*
 * Data memory access path between the core-side controller and the store
 * end. Holds bank selector, pointer or direct address, write strobe and
 * read data. Assumes both ends share hclk; reads are combinational.
 */
`timescale 1ns/1ps
interface etw_if;
    logic dm_bank;
    logic [7:0] dm_addr;
    logic dm_indirect;
    logic dm_wr;
    logic [7:0] dm_wdata;
    logic [7:0] dm_rdata;

    modport store (
        input dm_bank,
        input dm_addr,
        input dm_indirect,
        input dm_wr,
        input dm_wdata,
        output dm_rdata
    );

    modport ctrl (
        output dm_bank,
        output dm_addr,
        output dm_indirect,
        output dm_wr,
        output dm_wdata,
        input dm_rdata
    );
endinterface

// ===== hw/etw_store_end.sv
/*
 * Store end: the port control register reached only through the second
 * indirect window, and the 128x8 serial store driven by its bits.
 * Assumes the controller end shares hclk and holds the access signals
 * stable for the cycle in which dm_wr is high.
 */
// Added by the designer: the data memory access port from the controller end.
`timescale 1ns/1ps
module etw_store_end (
    input wire logic hclk,
    input wire logic hresetn,
    etw_if.store dm,
    output logic store_select,
    output logic store_serial_clock,
    output logic store_serial_in,
    output logic store_serial_out,
    output logic store_serial_out_en,
    output logic store_busy
);

    // ==========================================================
    // Port control register
    // ==========================================================
    logic cs_q, sk_q, di_q;
    logic port_hit;
    logic out_en, out_val;

    // Pointer bit 7 is ignored, so 40H and C0H both reach the register.
    assign port_hit = dm.dm_indirect && (dm.dm_bank == etw_pkg::PORT_BANK) &&
                      (dm.dm_addr[6:0] == etw_pkg::PORT_OFFSET);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cs_q <= 1'b0;
            sk_q <= 1'b0;
            di_q <= 1'b0;
        end else if (dm.dm_wr && port_hit) begin
            cs_q <= dm.dm_wdata[etw_pkg::BIT_SELECT];
            sk_q <= dm.dm_wdata[etw_pkg::BIT_SERIAL_CLOCK];
            di_q <= dm.dm_wdata[etw_pkg::BIT_SERIAL_IN];
        end
    end

    // A floating output line reads back as zero.
    assign dm.dm_rdata = port_hit ? {out_en & out_val, di_q, sk_q, cs_q, etw_pkg::PORT_LOW_BITS}
                                  : 8'h00;

    assign store_select = cs_q;
    assign store_serial_clock = sk_q;
    assign store_serial_in = di_q;

    // ==========================================================
    // Edge detection on the register-driven lines
    // ==========================================================
    logic sk_prev_q, cs_prev_q;
    logic sk_rise, cs_fall;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sk_prev_q <= 1'b0;
            cs_prev_q <= 1'b0;
        end else begin
            sk_prev_q <= sk_q;
            cs_prev_q <= cs_q;
        end
    end

    assign sk_rise = sk_q & ~sk_prev_q;
    assign cs_fall = cs_prev_q & ~cs_q;

    // ==========================================================
    // Instruction sequencer
    // ==========================================================
    etw_pkg::etw_state_t state_q;
    logic [2:0] cnt_q;
    logic [1:0] code_q;
    logic [6:0] addr_q;
    logic [7:0] data_q;
    logic do_q;
    logic enable_q;
    logic pend_q;
    logic ready_q;
    logic [15:0] wait_q;
    logic commit;
    logic [6:0] addr_next;
    logic [1:0] ext_op;
    logic [7:0] rd_byte;
    logic [7:0] mem [etw_pkg::STORE_WORDS];

    assign addr_next = {addr_q[5:0], di_q};
    assign ext_op = code_q == etw_pkg::CODE_EXT ? addr_q[6:5] : etw_pkg::EXT_DISABLE;
    assign commit = (state_q == etw_pkg::ST_BUSY) && (wait_q == 16'h0000);
    assign rd_byte = mem[addr_q];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= etw_pkg::ST_IDLE;
            cnt_q <= 3'h0;
            code_q <= 2'h0;
            addr_q <= 7'h00;
            data_q <= 8'h00;
            do_q <= 1'b0;
        end else if (state_q == etw_pkg::ST_BUSY) begin
            if (commit) begin
                state_q <= etw_pkg::ST_IDLE;
            end
        end else if (!cs_q) begin
            if (cs_fall && (state_q == etw_pkg::ST_HOLD) && pend_q) begin
                state_q <= etw_pkg::ST_BUSY;
            end else begin
                state_q <= etw_pkg::ST_IDLE;
            end
        end else if (sk_rise) begin
            case (state_q)
                etw_pkg::ST_IDLE: begin
                    if (di_q) begin
                        state_q <= etw_pkg::ST_CODE;
                        cnt_q <= 3'h0;
                    end
                end
                etw_pkg::ST_CODE: begin
                    code_q <= {code_q[0], di_q};
                    cnt_q <= 3'(cnt_q + 3'h1);
                    if (cnt_q == etw_pkg::CODE_LAST_BIT) begin
                        state_q <= etw_pkg::ST_ADDR;
                        cnt_q <= 3'h0;
                    end
                end
                etw_pkg::ST_ADDR: begin
                    addr_q <= addr_next;
                    cnt_q <= 3'(cnt_q + 3'h1);
                    if (cnt_q == etw_pkg::ADDR_LAST_BIT) begin
                        cnt_q <= 3'h0;
                        if (code_q == etw_pkg::CODE_READ) begin
                            state_q <= etw_pkg::ST_READ;
                            do_q <= 1'b0;
                        end else if ((code_q == etw_pkg::CODE_WRITE) ||
                                     ((code_q == etw_pkg::CODE_EXT) && (addr_next[6:5] == etw_pkg::EXT_WRITE_ALL))) begin
                            state_q <= etw_pkg::ST_DATA;
                        end else begin
                            state_q <= etw_pkg::ST_HOLD;
                        end
                    end
                end
                etw_pkg::ST_DATA: begin
                    data_q <= {data_q[6:0], di_q};
                    cnt_q <= 3'(cnt_q + 3'h1);
                    if (cnt_q == etw_pkg::DATA_LAST_BIT) begin
                        state_q <= etw_pkg::ST_HOLD;
                    end
                end
                etw_pkg::ST_READ: begin
                    do_q <= rd_byte[~cnt_q];
                    cnt_q <= 3'(cnt_q + 3'h1);
                    if (cnt_q == etw_pkg::DATA_LAST_BIT) begin
                        addr_q <= 7'(addr_q + 7'h01);
                    end
                end
                etw_pkg::ST_HOLD: begin
                    state_q <= etw_pkg::ST_HOLD;
                end
                default: begin
                    state_q <= etw_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Program enable and pending internal cycle
    // ==========================================================
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable_q <= 1'b0;
        end else if (cs_q && sk_rise && (state_q == etw_pkg::ST_ADDR) &&
                     (cnt_q == etw_pkg::ADDR_LAST_BIT) && (code_q == etw_pkg::CODE_EXT)) begin
            if (addr_next[6:5] == etw_pkg::EXT_ENABLE) begin
                enable_q <= 1'b1;
            end else if (addr_next[6:5] == etw_pkg::EXT_DISABLE) begin
                enable_q <= 1'b0;
            end
        end
    end

    // Reads never depend on the enable; only cycles that change the array do.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_q <= 1'b0;
        end else if (state_q != etw_pkg::ST_BUSY) begin
            pend_q <= enable_q && ((code_q == etw_pkg::CODE_WRITE) || (code_q == etw_pkg::CODE_ERASE) ||
                      (ext_op == etw_pkg::EXT_ERASE_ALL) || (ext_op == etw_pkg::EXT_WRITE_ALL));
        end
    end

    // ==========================================================
    // Internal write cycle timer and ready indication
    // ==========================================================
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wait_q <= 16'h0000;
        end else if (state_q != etw_pkg::ST_BUSY) begin
            wait_q <= 16'(etw_pkg::WR_CYCLES - 1);
        end else if (wait_q != 16'h0000) begin
            wait_q <= 16'(wait_q - 16'h0001);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ready_q <= 1'b0;
        end else if (commit) begin
            ready_q <= 1'b1;
        end else if (!cs_q || (state_q != etw_pkg::ST_IDLE)) begin
            ready_q <= 1'b0;
        end
    end

    assign out_en = (state_q == etw_pkg::ST_READ) ||
                    (cs_q && ((state_q == etw_pkg::ST_BUSY) || ready_q));
    assign out_val = (state_q == etw_pkg::ST_READ) ? do_q : ready_q;
    assign store_serial_out = out_en & out_val;
    assign store_serial_out_en = out_en;
    assign store_busy = state_q == etw_pkg::ST_BUSY;

    // ==========================================================
    // Nonvolatile array
    // ==========================================================
    // No reset on the array: its contents model retention across power loss.
    genvar gi;
    generate
        for (gi = 0; gi < etw_pkg::STORE_WORDS; gi++) begin : g_word
            always_ff @(posedge hclk) begin
                if (commit && ((code_q == etw_pkg::CODE_EXT) || (addr_q == 7'(gi)))) begin
                    if ((code_q == etw_pkg::CODE_ERASE) || (ext_op == etw_pkg::EXT_ERASE_ALL)) begin
                        mem[gi] <= etw_pkg::ERASED_BYTE;
                    end else begin
                        mem[gi] <= data_q;
                    end
                end
            end
        end
    endgenerate

endmodule

// ===== hw/etw_ctrl_end.sv
/*
 * Controller end: an AHB-Lite slave whose registers stand for the bank
 * selector, second memory pointer, second indirect window and a direct
 * address path, turned into data memory accesses toward the store end.
 * Assumes a single master, word transfers only, and a shared hclk.
 */
`timescale 1ns/1ps
module etw_ctrl_end (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    etw_if.ctrl dm
);

    // ==========================================================
    // Address phase capture
    // ==========================================================
    logic accept;
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic [1:0] rd_wait_q;
    logic [7:0] rd_addr_q;
    logic rd_ind_q;

    assign accept = hsel && hready && htrans[1] && (hsize == etw_pkg::HSIZE_WORD);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= accept && hwrite;
            if (accept && hwrite) begin
                wr_addr_q <= haddr[7:0];
            end
        end
    end

    // Reads wait two cycles so that a window write issued just before lands first.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_wait_q <= 2'h0;
            rd_addr_q <= 8'h00;
            rd_ind_q <= 1'b0;
        end else if (accept && !hwrite) begin
            rd_wait_q <= etw_pkg::RD_WAIT_FIRST;
            rd_addr_q <= haddr[7:0];
            rd_ind_q <= haddr[7:0] == etw_pkg::REG_WINDOW;
        end else if (rd_wait_q == etw_pkg::RD_WAIT_FIRST) begin
            rd_wait_q <= etw_pkg::RD_WAIT_SECOND;
        end else begin
            rd_wait_q <= 2'h0;
        end
    end

    assign hreadyout = rd_wait_q == 2'h0;
    assign hresp = 1'b0;

    // ==========================================================
    // Own registers
    // ==========================================================
    logic bank_q;
    logic [7:0] pointer_q;
    logic [7:0] direct_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bank_q <= 1'b0;
            pointer_q <= 8'h00;
            direct_q <= 8'h00;
        end else if (wr_pend_q) begin
            if (wr_addr_q == etw_pkg::REG_BANK) begin
                bank_q <= hwdata[0];
            end
            if (wr_addr_q == etw_pkg::REG_POINTER) begin
                pointer_q <= hwdata[7:0];
            end
            if (wr_addr_q == etw_pkg::REG_DIRECT_ADDR) begin
                direct_q <= hwdata[7:0];
            end
        end
    end

    // ==========================================================
    // Data memory access toward the store end
    // ==========================================================
    logic dm_wr_q;
    logic [7:0] dm_wdata_q;
    logic wr_ind_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dm_wr_q <= 1'b0;
            dm_wdata_q <= 8'h00;
            wr_ind_q <= 1'b0;
        end else begin
            dm_wr_q <= wr_pend_q && ((wr_addr_q == etw_pkg::REG_WINDOW) ||
                                     (wr_addr_q == etw_pkg::REG_DIRECT_DATA));
            if (wr_pend_q) begin
                dm_wdata_q <= hwdata[7:0];
                wr_ind_q <= wr_addr_q == etw_pkg::REG_WINDOW;
            end
        end
    end

    assign dm.dm_wr = dm_wr_q;
    assign dm.dm_wdata = dm_wdata_q;
    assign dm.dm_bank = bank_q;
    assign dm.dm_indirect = dm_wr_q ? wr_ind_q : rd_ind_q;
    assign dm.dm_addr = dm.dm_indirect ? pointer_q : direct_q;

    // ==========================================================
    // Read data
    // ==========================================================
    logic [31:0] hrdata_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
        end else if (rd_wait_q == etw_pkg::RD_WAIT_SECOND) begin
            case (rd_addr_q)
                etw_pkg::REG_BANK: hrdata_q <= {31'h0000_0000, bank_q};
                etw_pkg::REG_POINTER: hrdata_q <= {24'h00_0000, 1'b1, pointer_q[6:0]};
                etw_pkg::REG_DIRECT_ADDR: hrdata_q <= {24'h00_0000, direct_q};
                etw_pkg::REG_WINDOW: hrdata_q <= {24'h00_0000, dm.dm_rdata};
                etw_pkg::REG_DIRECT_DATA: hrdata_q <= {24'h00_0000, dm.dm_rdata};
                default: hrdata_q <= 32'h0000_0000;
            endcase
        end
    end

    assign hrdata = hrdata_q;

endmodule

// ===== testbench/etw_properties.sv
/*
 * Checker for the data memory path and the store lines of the port.
 * Assumes one clock, hclk, and the active low reset hresetn.
 */
`timescale 1ns/1ps
module etw_properties (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic dm_bank,
    input wire logic [7:0] dm_addr,
    input wire logic dm_indirect,
    input wire logic dm_wr,
    input wire logic [7:0] dm_wdata,
    input wire logic [7:0] dm_rdata,
    input wire logic store_select,
    input wire logic store_serial_clock,
    input wire logic store_serial_in,
    input wire logic store_serial_out,
    input wire logic store_serial_out_en,
    input wire logic store_busy
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ==========================================================
    // Port register access and serial output line
    // ==========================================================
    sequence port_hit_s;
        dm_indirect && dm_bank && dm_addr[6:0] == 7'h40;
    endsequence
    sequence port_wr_s;
        port_hit_s ##0 dm_wr;
    endsequence
    low_bits_zero_a: assert property (dm_rdata[3:0] == 4'h0)
        else $error("port low bits not zero");
    direct_no_hit_a: assert property (!dm_indirect |-> dm_rdata == 8'h00)
        else $error("direct access reached the port");
    other_place_a: assert property (dm_indirect && !(dm_bank && dm_addr[6:0] == 7'h40) |-> dm_rdata == 8'h00)
        else $error("port seen at another place");
    read_mirror_a: assert property (port_hit_s |-> dm_rdata[7:4] == {store_serial_out, store_serial_in,
        store_serial_clock, store_select})
        else $error("port read does not mirror the lines");
    select_follow_a: assert property (port_wr_s |=> store_select == $past(dm_wdata[4]))
        else $error("select line did not follow bit 4");
    clock_follow_a: assert property (port_wr_s |=> store_serial_clock == $past(dm_wdata[5]))
        else $error("serial clock did not follow bit 5");
    input_follow_a: assert property (port_wr_s |=> store_serial_in == $past(dm_wdata[6]))
        else $error("serial input did not follow bit 6");
    float_low_a: assert property (!store_serial_out_en |-> !store_serial_out)
        else $error("output shows a value while floating");
    busy_poll_a: assert property (store_busy && store_serial_out_en |-> !store_serial_out)
        else $error("output high during the internal cycle");
endmodule

// ===== testbench/eeprom_three_wire_port_tb.sv
/*
 * Bench: both ends joined by the interface, software driven over AHB-Lite.
 * Assumes the hand-over timing: two read wait states, about two cycles
 * from a clock rise to the output bit.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
    $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module eeprom_three_wire_port_tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = etw_pkg::HSIZE_WORD;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic sel_w, sk_w, di_w, do_w, doen_w, busy_w;
    int mismatches = 0;
    int checks = 0;
    etw_if dm_bus();
    always #25 hclk = ~hclk;
    etw_ctrl_end i_etw_ctrl_end (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .dm(dm_bus));
    etw_store_end i_etw_store_end (.hclk(hclk), .hresetn(hresetn), .dm(dm_bus), .store_select(sel_w),
        .store_serial_clock(sk_w), .store_serial_in(di_w), .store_serial_out(do_w),
        .store_serial_out_en(doen_w), .store_busy(busy_w));
    etw_properties i_props (.hclk(hclk), .hresetn(hresetn), .dm_bank(dm_bus.dm_bank), .dm_addr(dm_bus.dm_addr),
        .dm_indirect(dm_bus.dm_indirect), .dm_wr(dm_bus.dm_wr), .dm_wdata(dm_bus.dm_wdata),
        .dm_rdata(dm_bus.dm_rdata), .store_select(sel_w), .store_serial_clock(sk_w), .store_serial_in(di_w),
        .store_serial_out(do_w), .store_serial_out_en(doen_w), .store_busy(busy_w));
    // ==========================================================
    // Bus and serial tasks
    // ==========================================================
    task automatic ahb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= etw_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata[7:0];
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        ahb(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] r);
        ahb(1'b0, a, 8'h00, r);
    endtask
    task automatic port(input logic s, input logic k, input logic d);
        wr(etw_pkg::REG_WINDOW, {1'b0, d, k, s, 4'h0});
    endtask
    task automatic bit_out(input logic b);
        port(1'b1, 1'b0, b);
        port(1'b1, 1'b1, b);
    endtask
    task automatic cmd(input logic [1:0] c, input logic [6:0] a);
        bit_out(1'b1);
        for (int i = 1; i >= 0; i--) bit_out(c[i]);
        for (int i = 6; i >= 0; i--) bit_out(a[i]);
    endtask
    task automatic bit_in(output logic b);
        logic [7:0] r;
        port(1'b1, 1'b0, 1'b0);
        port(1'b1, 1'b1, 1'b0);
        repeat (4) @(posedge hclk);
        rd(etw_pkg::REG_WINDOW, r);
        b = r[7];
    endtask
    task automatic read_chk(input logic [6:0] a, input logic [7:0] e0, input logic [7:0] e1);
        logic b;
        logic [7:0] v;
        logic [7:0] r;
        cmd(etw_pkg::CODE_READ, a);
        // The dummy zero already stands after the clock rise that carried A0.
        rd(etw_pkg::REG_WINDOW, r);
        `CHK(r[7], 1'b0)
        for (int k = 0; k < 2; k++) begin
            for (int i = 7; i >= 0; i--) begin
                bit_in(b);
                v[i] = b;
            end
            `CHK(v, k ? e1 : e0)
        end
        port(1'b0, 1'b0, 1'b0);
    endtask
    task automatic prog(input logic [1:0] c, input logic [6:0] a, input logic [7:0] d, input bit data);
        logic [7:0] r;
        cmd(c, a);
        if (data) for (int i = 7; i >= 0; i--) bit_out(d[i]);
        port(1'b0, 1'b0, 1'b0);
        port(1'b1, 1'b0, 1'b0);
        rd(etw_pkg::REG_WINDOW, r);
        `CHK(r[7], 1'b0)
        while (r[7] !== 1'b1) rd(etw_pkg::REG_WINDOW, r);
        port(1'b0, 1'b0, 1'b0);
    endtask
    task automatic ext(input logic [1:0] op);
        cmd(etw_pkg::CODE_EXT, {op, 5'h00});
        port(1'b0, 1'b0, 1'b0);
    endtask
    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_regs;
        logic [7:0] r;
        rd(etw_pkg::REG_POINTER, r);
        `CHK(r, 8'h80)
        wr(etw_pkg::REG_BANK, 8'h01);
        wr(etw_pkg::REG_POINTER, 8'h40);
        wr(etw_pkg::REG_WINDOW, 8'hFF);
        rd(etw_pkg::REG_WINDOW, r);
        `CHK(r, 8'h70)
        `CHK({di_w, sk_w, sel_w}, 3'h7)
        wr(etw_pkg::REG_DIRECT_ADDR, 8'h40);
        wr(etw_pkg::REG_DIRECT_DATA, 8'h00);
        rd(etw_pkg::REG_WINDOW, r);
        `CHK(r, 8'h70)
        wr(etw_pkg::REG_POINTER, 8'h41);
        wr(etw_pkg::REG_WINDOW, 8'h00);
        // A window write lands one edge after its data phase.
        repeat (2) @(posedge hclk);
        `CHK(sel_w, 1'b1)
        wr(etw_pkg::REG_BANK, 8'h00);
        wr(etw_pkg::REG_POINTER, 8'h40);
        wr(etw_pkg::REG_WINDOW, 8'h00);
        repeat (2) @(posedge hclk);
        `CHK(sel_w, 1'b1)
        wr(etw_pkg::REG_BANK, 8'h01);
        port(1'b0, 1'b0, 1'b0);
        rd(8'h20, r);
        `CHK(r, 8'h00)
        `CHK(hresp, 1'b0)
    endtask
    task automatic t_cmds;
        port(1'b0, 1'b0, 1'b0);
        ext(etw_pkg::EXT_ENABLE);
        prog(etw_pkg::CODE_WRITE, 7'h7F, 8'hA5, 1'b1);
        prog(etw_pkg::CODE_WRITE, 7'h00, 8'h3C, 1'b1);
        read_chk(7'h7F, 8'hA5, 8'h3C);
        prog(etw_pkg::CODE_ERASE, 7'h7F, 8'h00, 1'b0);
        read_chk(7'h7F, etw_pkg::ERASED_BYTE, 8'h3C);
        prog(etw_pkg::CODE_EXT, {etw_pkg::EXT_WRITE_ALL, 5'h00}, 8'h5A, 1'b1);
        read_chk(7'h10, 8'h5A, 8'h5A);
        prog(etw_pkg::CODE_EXT, {etw_pkg::EXT_ERASE_ALL, 5'h00}, 8'h00, 1'b0);
        read_chk(7'h7F, 8'hFF, 8'hFF);
    endtask
    task automatic t_disabled;
        ext(etw_pkg::EXT_DISABLE);
        cmd(etw_pkg::CODE_WRITE, 7'h00);
        // Zero data differs from the erased value, so a write that slips through shows.
        for (int i = 7; i >= 0; i--) bit_out(1'b0);
        port(1'b0, 1'b0, 1'b0);
        repeat (4) @(posedge hclk);
        `CHK(busy_w, 1'b0)
        read_chk(7'h00, 8'hFF, 8'hFF);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Longest expected run is near 2000 cycles, so the limit leaves ample margin.
    initial begin
        repeat (60000) @(posedge hclk);
        mismatches++;
        tally_and_finish();
    end
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_cmds();
        t_disabled();
        tally_and_finish();
    end
endmodule
